// ### core/lpcg_pkg.sv
package lpcg_pkg;

  // Register byte addresses
  localparam logic [11:0] LPCG_MODE_OFS   = 12'h000;
  localparam logic [11:0] LPCG_SRC_OFS    = 12'h004;
  localparam logic [11:0] LPCG_IE_OFS     = 12'h008;
  localparam logic [11:0] LPCG_STAT_OFS   = 12'h00c;
  localparam logic [11:0] LPCG_VEC_OFS    = 12'h010;

  // Field positions
  localparam int LPCG_SRC_ACLK_HF_BIT  = 0;
  localparam int LPCG_SRC_MAIN_DTO_BIT = 1;
  localparam int LPCG_IE_GIE_BIT       = 16;

  // Reset values
  localparam logic [2:0]  LPCG_MODE_RST = 3'h0;
  localparam logic [1:0]  LPCG_SRC_RST  = 2'h2;
  localparam logic [15:0] LPCG_IE_RST   = 16'h0000;

  // Vector table at the top of the 16-bit address space
  localparam logic [15:0] LPCG_VEC_BASE  = 16'hffe0;
  localparam logic [15:0] LPCG_VEC_RESET = 16'hfffe;

  // Oscillator settling
  localparam int LPCG_DTO_SETTLE_NS = 6000;
  localparam int LPCG_CLK_PERIOD_NS = 10;
  localparam int LPCG_DTO_SETTLE_CYC = LPCG_DTO_SETTLE_NS / LPCG_CLK_PERIOD_NS;

  // Operating states, encoded as software writes them
  localparam logic [2:0] LPCG_FULL_RUN_STATE = 3'h0;
  localparam logic [2:0] LPCG_SLEEP_LEVEL_0  = 3'h1;
  localparam logic [2:0] LPCG_SLEEP_LEVEL_1  = 3'h2;
  localparam logic [2:0] LPCG_SLEEP_LEVEL_2  = 3'h3;
  localparam logic [2:0] LPCG_SLEEP_LEVEL_3  = 3'h4;
  localparam logic [2:0] LPCG_SLEEP_LEVEL_4  = 3'h5;

  typedef enum logic [3:0] {
    LPCG_ST_RUN    = 4'b0001,
    LPCG_ST_SLEEP  = 4'b0010,
    LPCG_ST_SETTLE = 4'b0100,
    LPCG_ST_SERVE  = 4'b1000
  } lpcg_state_t;

endpackage

// ### core/lpcg_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - In the full-run state all three clocks run.
// - Sleep level 0 halts the core and gates its clock; auxiliary and peripheral clocks run.
// - Sleep level 1 is level 0 plus the tuned oscillator off when it does not feed the core.
// - Sleep level 2 stops core and peripheral clocks, keeps the oscillator and auxiliary clock.
// - Sleep level 3 stops core and peripheral clocks and the oscillator, keeps auxiliary clock.
// - Sleep level 4 stops every clock, the oscillator and the crystal.
// - Six states in all, each picked by a software write.
// - An interrupt wakes any sleep level, runs its handler and returns to the same level.
// - Vectors sit at the top 32 bytes; each holds the handler's 16-bit address.
// - A nonmaskable source is taken regardless of both enables.
// - A partially maskable source obeys its own enable but not the general one.
// - The auxiliary clock comes from the watch crystal or the fast crystal.
// - The core runs on the main clock and peripherals on the peripheral clock.
// - The tuned oscillator is taken as stable 6 us after start.
// - Unassigned register bits hold no storage and read zero.
module lpcg_ctrl
  import lpcg_pkg::*;
#(
  parameter int NSRC = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  input  wire logic             hsel,
  input  wire logic [11:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [NSRC-1:0]  irq_req,
  input  wire logic [NSRC-1:0]  irq_nmi,
  input  wire logic [NSRC-1:0]  irq_pmask,
  input  wire logic             irq_return,
  output logic                  irq_ack,
  output logic [15:0]           vec_addr,
  output logic                  cpu_halt,
  output logic                  main_clk_en,
  output logic                  peripheral_clock_en,
  output logic                  aux_clk_en,
  output logic                  aux_src_hf,
  output logic                  dto_dc_en,
  output logic                  xtal_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic        ap_we_q, ap_we_d;
  logic        ap_re_q, ap_re_d;
  logic [11:0] ap_adr_q, ap_adr_d;
  logic [2:0]  mode_q, mode_d;
  logic [1:0]  src_q, src_d;
  logic [NSRC-1:0] ie_q, ie_d;
  logic        gie_q, gie_d;
  logic [31:0] rdata_q, rdata_d;
  lpcg_state_t st_q, st_d;
  logic [2:0]  saved_q, saved_d;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0]  src_idx_q, src_idx_d;
  logic [15:0] vec_q, vec_d;
  logic        ack_q, ack_d;
  logic [NSRC-1:0] eligible;
  logic [3:0]  pick;
  logic        any_irq;
  logic        need_dto;
  logic        wr_mode;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  always_comb begin
    ap_we_d  = ap_we_q;
    ap_re_d  = ap_re_q;
    ap_adr_d = ap_adr_q;
    if (hready) begin
      ap_we_d  = hsel && htrans[1] && hwrite;
      ap_re_d  = hsel && htrans[1] && !hwrite;
      ap_adr_d = haddr;
    end
  end

  assign wr_mode = ap_we_q && (ap_adr_q == LPCG_MODE_OFS);

  always_comb begin
    src_d   = src_q;
    ie_d    = ie_q;
    gie_d   = gie_q;
    rdata_d = 32'h0000_0000;
    if (ap_we_q) begin
      case (ap_adr_q)
        LPCG_SRC_OFS: src_d = hwdata[1:0];
        LPCG_IE_OFS: begin
          ie_d  = hwdata[NSRC-1:0];
          gie_d = hwdata[LPCG_IE_GIE_BIT];
        end
        default: ;
      endcase
    end
    if (ap_re_d) begin
      // Unassigned bits have no flop behind them and read zero
      case (ap_adr_d)
        LPCG_MODE_OFS: rdata_d = {29'h0, mode_q};
        LPCG_SRC_OFS:  rdata_d = {30'h0, src_q};
        LPCG_IE_OFS:   rdata_d = {15'h0, gie_q, 16'(ie_q)};
        LPCG_STAT_OFS: rdata_d = {20'h0, 4'(st_q), 5'h0, saved_q};
        LPCG_VEC_OFS:  rdata_d = {16'h0, vec_q};
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt selection
  always_comb begin
    eligible = irq_req & (irq_nmi | (irq_pmask & ie_q) | (ie_q & {NSRC{gie_q}}));
    any_irq  = |eligible;
    pick     = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (eligible[i]) pick = 4'(i);
    end
  end

  // The tuned oscillator must restart if the level switched it off
  assign need_dto = !dto_dc_en;

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  always_comb begin
    st_d      = st_q;
    mode_d    = mode_q;
    saved_d   = saved_q;
    cnt_d     = cnt_q;
    src_idx_d = src_idx_q;
    vec_d     = vec_q;
    ack_d     = 1'b0;
    case (st_q)
      LPCG_ST_RUN: begin
        if (wr_mode && hwdata[2:0] <= LPCG_SLEEP_LEVEL_4) begin
          mode_d = hwdata[2:0];
          if (hwdata[2:0] != LPCG_FULL_RUN_STATE) st_d = LPCG_ST_SLEEP;
        end
      end
      LPCG_ST_SLEEP: begin
        if (any_irq) begin
          // Clocks restart at the wake edge so the settle count covers the whole start-up
          mode_d    = LPCG_FULL_RUN_STATE;
          saved_d   = mode_q;
          src_idx_d = pick;
          cnt_d     = need_dto ? 16'(LPCG_DTO_SETTLE_CYC) : 16'h0001;
          st_d      = LPCG_ST_SETTLE;
        end
      end
      LPCG_ST_SETTLE: begin
        mode_d = LPCG_FULL_RUN_STATE;
        cnt_d  = cnt_q - 16'h0001;
        if (cnt_q <= 16'h0001) begin
          vec_d = LPCG_VEC_BASE + {11'h0, src_idx_q, 1'b0};
          ack_d = 1'b1;
          st_d  = LPCG_ST_SERVE;
        end
      end
      LPCG_ST_SERVE: begin
        if (irq_return) begin
          mode_d = saved_q;
          st_d   = (saved_q == LPCG_FULL_RUN_STATE) ? LPCG_ST_RUN : LPCG_ST_SLEEP;
        end
      end
      default: st_d = LPCG_ST_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_we_q   <= 1'b0;
      ap_re_q   <= 1'b0;
      ap_adr_q  <= 12'h000;
      mode_q    <= LPCG_MODE_RST;
      src_q     <= LPCG_SRC_RST;
      ie_q      <= '0;
      gie_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      st_q      <= LPCG_ST_RUN;
      saved_q   <= LPCG_MODE_RST;
      cnt_q     <= 16'h0000;
      src_idx_q <= 4'h0;
      vec_q     <= LPCG_VEC_RESET;
      ack_q     <= 1'b0;
    end else if (clk_en) begin
      ap_we_q   <= ap_we_d;
      ap_re_q   <= ap_re_d;
      ap_adr_q  <= ap_adr_d;
      mode_q    <= mode_d;
      src_q     <= src_d;
      ie_q      <= ie_d;
      gie_q     <= gie_d;
      rdata_q   <= rdata_d;
      st_q      <= st_d;
      saved_q   <= saved_d;
      cnt_q     <= cnt_d;
      src_idx_q <= src_idx_d;
      vec_q     <= vec_d;
      ack_q     <= ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gates, decoded straight from the current level
  always_comb begin
    main_clk_en         = (mode_q == LPCG_FULL_RUN_STATE);
    cpu_halt            = !main_clk_en || (st_q == LPCG_ST_SETTLE);
    peripheral_clock_en = (mode_q <= LPCG_SLEEP_LEVEL_1);
    aux_clk_en          = (mode_q != LPCG_SLEEP_LEVEL_4);
    xtal_en             = aux_clk_en;
    dto_dc_en           = (mode_q <= LPCG_SLEEP_LEVEL_0) || (mode_q == LPCG_SLEEP_LEVEL_2)
                       || (mode_q == LPCG_SLEEP_LEVEL_1 && src_q[LPCG_SRC_MAIN_DTO_BIT]);
    aux_src_hf          = src_q[LPCG_SRC_ACLK_HF_BIT];
  end

  assign irq_ack  = ack_q;
  assign vec_addr = vec_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_wake;
    (st_q == LPCG_ST_SLEEP) && any_irq && clk_en;
  endsequence

  sequence s_return;
    (st_q == LPCG_ST_SERVE) && irq_return && clk_en;
  endsequence

  // Unbroken run time of the tuned oscillator, held at the settle count
  // Out of reset the oscillator counts as settled, so an early wake is not flagged
  logic [15:0] osc_run_q, osc_run_d;

  always_comb begin
    osc_run_d = osc_run_q;
    if (!dto_dc_en) begin
      osc_run_d = 16'h0000;
    end else if (osc_run_q < 16'(LPCG_DTO_SETTLE_CYC)) begin
      osc_run_d = osc_run_q + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_run_q <= 16'(LPCG_DTO_SETTLE_CYC);
    end else if (clk_en) begin
      osc_run_q <= osc_run_d;
    end
  end

  AST_RUN_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == LPCG_FULL_RUN_STATE |-> main_clk_en && peripheral_clock_en && aux_clk_en)
    else $error("clock off in full run");
  AST_L0: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == LPCG_SLEEP_LEVEL_0 |-> !main_clk_en && cpu_halt && peripheral_clock_en && aux_clk_en)
    else $error("level 0 gating wrong");
  AST_L1: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == LPCG_SLEEP_LEVEL_1 |-> dto_dc_en == src_q[LPCG_SRC_MAIN_DTO_BIT])
    else $error("level 1 oscillator wrong");
  AST_L2: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == LPCG_SLEEP_LEVEL_2 |-> !peripheral_clock_en && dto_dc_en && aux_clk_en)
    else $error("level 2 gating wrong");
  AST_L3: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == LPCG_SLEEP_LEVEL_3 |-> !peripheral_clock_en && !dto_dc_en && aux_clk_en)
    else $error("level 3 gating wrong");
  AST_L4: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == LPCG_SLEEP_LEVEL_4 |-> !aux_clk_en && !xtal_en && !dto_dc_en && !main_clk_en)
    else $error("level 4 gating wrong");
  AST_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wake |=> st_q == LPCG_ST_SETTLE && saved_q == $past(mode_q))
    else $error("wake not taken");
  AST_VEC: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_q |-> vec_q[15:5] == LPCG_VEC_BASE[15:5] && !vec_q[0])
    else $error("vector out of range");
  AST_NMI: assert property (@(posedge hclk) disable iff (!hresetn)
    |(irq_req & irq_nmi) |-> any_irq)
    else $error("nonmaskable blocked");
  AST_PM: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_req == (irq_pmask & ie_q)) && |irq_req |-> any_irq)
    else $error("partial mask blocked");
  AST_CLKFIRST: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_q |-> main_clk_en && dto_dc_en)
    else $error("vector before clock");
  AST_OSC_SETTLED: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_q |-> osc_run_q == 16'(LPCG_DTO_SETTLE_CYC))
    else $error("vector before oscillator settled");
  AST_SETTLE_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == LPCG_ST_SETTLE |-> cpu_halt && main_clk_en)
    else $error("core not held while clocks settle");
  AST_ACK_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_q && clk_en |=> !ack_q)
    else $error("vector strobe longer than one cycle");
  AST_RETURN: assert property (@(posedge hclk) disable iff (!hresetn)
    s_return |=> mode_q == $past(saved_q))
    else $error("return did not restore level");

endmodule

`default_nettype wire

// ### testbench/lpcg_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module lpcg_core_model
  import lpcg_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        irq_ack,
  input  wire logic [15:0] vec_addr,
  input  wire logic        main_clk_en,
  output logic             irq_return,
  output logic [7:0]       bad_q
);
  // Fixed handler length keeps the return well clear of the fetch
  logic [3:0] run_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q      <= 4'h0;
      irq_return <= 1'b0;
      bad_q      <= 8'h00;
    end else begin
      irq_return <= (run_q == 4'h1);
      if (run_q != 4'h0)
        run_q <= run_q - 4'h1;
      if (irq_ack) begin
        run_q <= 4'h6;
        // A fetch on a stopped core clock or outside the table is counted
        if (!main_clk_en || vec_addr < LPCG_VEC_BASE || vec_addr[0])
          bad_q <= bad_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import lpcg_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_return, irq_ack;
  logic        cpu_halt, main_clk_en, peripheral_clock_en, aux_clk_en, clk_en;
  logic        aux_src_hf, dto_dc_en, xtal_en;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] irq_req, irq_nmi, irq_pmask, vec_addr;
  logic [7:0]  bad;
  int          err_total, comparisons;
  // Gates as {halt, core, peripheral, aux, osc dc, crystal} for run and levels 0..4
  localparam logic [5:0] GATES [6] = '{6'h1f, 6'h2f, 6'h2f, 6'h27, 6'h25, 6'h20};
  //////////////////////////////////////////////////////////////////////////////
  lpcg_ctrl dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
    .irq_nmi(irq_nmi), .irq_pmask(irq_pmask), .irq_return(irq_return), .irq_ack(irq_ack),
    .vec_addr(vec_addr), .cpu_halt(cpu_halt), .main_clk_en(main_clk_en),
    .peripheral_clock_en(peripheral_clock_en), .aux_clk_en(aux_clk_en),
    .aux_src_hf(aux_src_hf), .dto_dc_en(dto_dc_en), .xtal_en(xtal_en));
  lpcg_core_model core (.hclk(hclk), .hresetn(hresetn), .irq_ack(irq_ack),
    .vec_addr(vec_addr), .main_clk_en(main_clk_en), .irq_return(irq_return), .bad_q(bad));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  function automatic logic [31:0] gates();
    return {26'h0, cpu_halt, main_clk_en, peripheral_clock_en, aux_clk_en, dto_dc_en, xtal_en};
  endfunction
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask
  // One single word transfer; read data is taken at the edge closing the data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    irq_req <= 16'h0;
    irq_nmi <= 16'h0;
    irq_pmask <= 16'h0;
    cyc(3);
    hresetn <= 1'b1;
    cyc(1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic reg_case();
    rst();
    chk(gates(), 32'(GATES[0]));
    chk(32'(vec_addr), 32'(LPCG_VEC_RESET));
    chk(32'(hresp), 32'h0);
    bus(1'b0, LPCG_SRC_OFS, 32'h0);
    chk(rd, 32'(LPCG_SRC_RST));
    bus(1'b0, LPCG_IE_OFS, 32'h0);
    chk(rd, 32'(LPCG_IE_RST));
    bus(1'b1, LPCG_SRC_OFS, 32'hffffffff);
    bus(1'b0, LPCG_SRC_OFS, 32'h0);
    chk(rd, 32'h3);
    chk(32'(aux_src_hf), 32'h1);
    bus(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, LPCG_MODE_OFS, 32'h6);
    bus(1'b0, LPCG_MODE_OFS, 32'h0);
    chk(rd, 32'(LPCG_FULL_RUN_STATE));
    // With the core off the tuned oscillator, level 1 may drop its dc generator
    bus(1'b1, LPCG_SRC_OFS, 32'h0);
    bus(1'b1, LPCG_MODE_OFS, 32'(LPCG_SLEEP_LEVEL_1));
    cyc(2);
    chk(32'(dto_dc_en), 32'h0);
    chk(32'(peripheral_clock_en), 32'h1);
  endtask
  // A low enable holds a sleeping block asleep with a request pending
  task automatic freeze_case();
    rst();
    bus(1'b1, LPCG_MODE_OFS, 32'(LPCG_SLEEP_LEVEL_0));
    clk_en <= 1'b0;
    irq_req[0] <= 1'b1;
    irq_nmi[0] <= 1'b1;
    cyc(8);
    chk(gates(), 32'(GATES[1]));
    chk(32'(irq_ack), 32'h0);
    clk_en <= 1'b1;
    cyc(3);
    chk(32'(irq_ack), 32'h1);
    irq_req[0] <= 1'b0;
    cyc(12);
  endtask
  // k is {nonmaskable, partially maskable, raise a request}
  task automatic run_case(input int m, input int s, input logic [2:0] k,
                          input logic [31:0] ie, input logic exp);
    int n, on;
    rst();
    bus(1'b1, LPCG_IE_OFS, ie);
    bus(1'b1, LPCG_MODE_OFS, 32'(m));
    cyc(2);
    chk(gates(), 32'(GATES[m]));
    bus(1'b0, LPCG_MODE_OFS, 32'h0);
    chk(rd, 32'(m));
    if (k[0]) begin
      irq_req[s] <= 1'b1;
      irq_nmi[s] <= k[2];
      irq_pmask[s] <= k[1];
      n = 0;
      on = 0;
      do begin
        @(posedge hclk);
        n++;
        if (dto_dc_en === 1'b1 && irq_ack !== 1'b1) on++;
      end while (irq_ack !== 1'b1 && n < 700);
      chk(32'(irq_ack), 32'(exp));
      if (exp) begin
        chk(32'(vec_addr), 32'(LPCG_VEC_BASE + 16'(2 * s)));
        chk(32'(on >= LPCG_DTO_SETTLE_CYC), 32'(!GATES[m][1]));
      end
      irq_req[s] <= 1'b0;
      bus(1'b0, LPCG_VEC_OFS, 32'h0);
      chk(rd, exp ? 32'(LPCG_VEC_BASE + 16'(2 * s)) : 32'(LPCG_VEC_RESET));
      cyc(12);
      chk(gates(), 32'(GATES[m]));
      bus(1'b0, LPCG_STAT_OFS, 32'h0);
      chk(rd, {20'h0, 4'(LPCG_ST_SLEEP), 5'h0, exp ? 3'(m) : 3'h0});
      chk(32'(bad), 32'h0);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 12'h000;
    hwrite = 1'b0;
    hsize = 3'h2;
    clk_en = 1'b1;
    hwdata = 32'h0;
    irq_req = 16'h0;
    irq_nmi = 16'h0;
    irq_pmask = 16'h0;
    err_total = 0;
    comparisons = 0;
    reg_case();
    freeze_case();
    for (int m = 0; m < 6; m++)
      run_case(m, 1, (m == 0) ? 3'b000 : 3'b101, 32'h0, 1'b1);
    run_case(1, 2, 3'b011, 32'h0, 1'b0);
    run_case(1, 2, 3'b011, 32'h4, 1'b1);
    run_case(1, 3, 3'b001, 32'h8, 1'b0);
    // General enable in bit 16 lets the plain maskable source through
    run_case(1, 3, 3'b001, 32'h10008, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
